// File: src/mps_sequencer.sv
// Motion path sequencer: path table, Wishbone slave, path state machine, motion command outputs
//
// Behaviour
// - Table holds 63 paths; type 1 speed, 2 single position, 3 auto position.
// - Type 1 ramps to target speed and keeps running there.
// - Speed unit bit clear means 0.1 r/min, set means position units per second.
// - Constant-speed target is limited to -60000 .. 60000.
// - Speed ramps from present speed at a rate set by the time index.
// - Constant-speed delay starts only after target speed is reached.
// - Without auto-advance, sequencing stops when the path completes.
// - With auto-advance, next path starts after completion plus delay.
// - Single positioning path leaves motor stopped until another trigger.
// - Auto positioning path proceeds to next path when positioning completes.
// - Two-bit mode picks fixed, present, previous target or latched base.
// - Positioning data is a signed 32-bit value in user position units.
// - A path with preempt set replaces the previous path, internally or externally.
// - Internal preempting path is called on completion, no trigger, delay kept.
// - Internal preempt gives the same target for previous-target and present-relative modes.
// - If the next path preempts, current delay counts from current path start.
// - Zero delay with preempting next path skips the current positioning path.
// - Speed path with auto-advance and delay starts positioning when delay ends.
// - External preempting trigger is merged into motion within one millisecond.
// - Overlap lets the next path start during current deceleration.
// - Overlapped path counts its delay from its own start.
//
// Our own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "mps_defs.svh"
module mps_sequencer
  import mps_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `MPS_TICK_CYC
)
(
  // Clock and reset
  input  wire logic               clock_in,
  input  wire logic               rstn_in,
  // Wishbone slave
  input  wire logic               wb_cyc_in,
  input  wire logic               wb_stb_in,
  input  wire logic               wb_we_in,
  input  wire logic        [11:0] wb_adr_in,
  input  wire logic        [3:0]  wb_sel_in,
  input  wire logic        [31:0] wb_dat_in,
  output logic             [31:0] wb_dat_out,
  output logic                    wb_ack_out,
  // Path trigger inputs
  input  wire logic        [5:0]  path_select_inputs_in,
  input  wire logic               path_select_strobe_in,
  // Motor feedback
  input  wire logic               position_done_in,
  input  wire logic               decel_phase_in,
  input  wire logic signed [31:0] present_position_in,
  input  wire logic signed [31:0] latched_position_in,
  // Motion command
  output logic                    move_start_out,
  output logic signed      [31:0] target_position_out,
  output logic signed      [31:0] velocity_cmd_out,
  output logic                    speed_mode_out,
  output logic                    speed_unit_out,
  output logic             [3:0]  speedup_time_index_out,
  output logic             [3:0]  slowdown_time_index_out,
  output logic             [3:0]  target_velocity_index_out,
  // Status
  output logic             [5:0]  active_path_out,
  output logic                    busy_out
);

  logic        [31:0] cfg_mem [0:63];
  logic        [31:0] data_mem [0:63];
  mps_state_type      state_ff;
  logic        [5:0]  path_ff;
  logic               internal_ff;
  logic        [7:0]  dly_cnt_ff;
  logic               counting_ff;
  logic        [31:0] tick_cnt_ff;
  logic               tick_ff;
  logic               trig_req_ff;
  logic        [5:0]  trig_idx_ff;
  logic               reached;

  // Bus decode
  logic               wb_req;
  logic               wb_wr;
  logic        [3:0]  page;
  logic        [5:0]  entry;
  logic        [31:0] wmask;
  logic        [31:0] nxt_rdata;

  assign wb_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wb_wr  = wb_req && wb_we_in;
  assign page   = wb_adr_in[11:8];
  assign entry  = wb_adr_in[7:2];
  assign wmask  = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

  // Entry 0 is not a path; it stays zero so a type of 0 never runs
  genvar gi;
  generate
    for (gi = 0; gi < 64; gi++)
    begin : g_table
      always_ff @(posedge clock_in or negedge rstn_in)
      begin
        if (!rstn_in)
        begin
          cfg_mem[gi]  <= `MPS_CFG_RESET;
          data_mem[gi] <= `MPS_DATA_RESET;
        end
        else if (wb_wr && gi != 0 && entry == 6'(gi))
        begin
          if (page == `MPS_PAGE_CFG)
            cfg_mem[gi] <= (cfg_mem[gi] & ~wmask) | (wb_dat_in & wmask);
          if (page == `MPS_PAGE_DATA)
            data_mem[gi] <= (data_mem[gi] & ~wmask) | (wb_dat_in & wmask);
        end
      end
    end
  endgenerate

  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    if (page == `MPS_PAGE_CFG)
      nxt_rdata = cfg_mem[entry];
    else if (page == `MPS_PAGE_DATA)
      nxt_rdata = data_mem[entry];
    else if (wb_adr_in == `MPS_REG_TRIGGER)
      nxt_rdata = {26'h000_0000, trig_idx_ff};
    else if (wb_adr_in == `MPS_REG_STATUS)
      nxt_rdata = {20'h0_0000, reached, internal_ff, state_ff, path_ff, busy_out, counting_ff};
    else if (wb_adr_in == `MPS_REG_LAST_TGT)
      nxt_rdata = target_position_out;
  end

  // One wait state; unmapped addresses answer with zero
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_out <= wb_req;
      if (wb_req && !wb_we_in)
        wb_dat_out <= nxt_rdata;
    end
  end

  // Software trigger, the path trigger parameter: a one-cycle request, lost if it cannot be taken
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      trig_req_ff <= 1'b0;
      trig_idx_ff <= 6'h00;
    end
    else if (wb_wr && wb_adr_in == `MPS_REG_TRIGGER && wb_sel_in[0])
    begin
      trig_req_ff <= 1'b1;
      trig_idx_ff <= wb_dat_in[5:0];
    end
    else
      trig_req_ff <= 1'b0;
  end

  // Millisecond tick for ramps and delays
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      tick_cnt_ff <= 32'h0000_0000;
      tick_ff     <= 1'b0;
    end
    else if (tick_cnt_ff >= TICK_CYCLES - 1)
    begin
      tick_cnt_ff <= 32'h0000_0000;
      tick_ff     <= 1'b1;
    end
    else
    begin
      tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
      tick_ff     <= 1'b0;
    end
  end

  // Current and following path
  logic        [31:0] cur_cfg;
  logic signed [31:0] cur_data;
  logic        [5:0]  nxt_idx;
  logic               nxt_preempt;
  logic               is_speed;
  logic               is_pos;
  logic        [7:0]  cur_dly;
  logic               skip;
  logic               from_start;
  logic               pos_done;
  logic               pos_continue;
  logic        [5:0]  ext_idx;
  logic               ext_take;
  logic signed [31:0] base;
  logic signed [31:0] nxt_target;
  logic signed [31:0] spd_target;
  logic        [31:0] ramp_step;
  logic               ramp_load;

  assign cur_cfg     = cfg_mem[path_ff];
  assign cur_data    = data_mem[path_ff];
  assign nxt_idx     = (path_ff == `MPS_PATH_COUNT) ? 6'h01 : path_ff + 6'h01;
  assign nxt_preempt = cfg_mem[nxt_idx][`MPS_F_PREEMPT];
  assign is_speed    = cur_cfg[`MPS_F_TYPE] == `MPS_TYPE_SPEED;
  assign is_pos      = cur_cfg[`MPS_F_TYPE] == `MPS_TYPE_POS_SINGLE || cur_cfg[`MPS_F_TYPE] == `MPS_TYPE_POS_AUTO;
  assign cur_dly     = 8'(cur_cfg[`MPS_F_DLY] * `MPS_DLY_STEP_MS);
  assign skip        = is_pos && cur_dly == 8'h00 && nxt_preempt;
  assign from_start  = is_pos && (cur_cfg[`MPS_F_OVERLAP] || nxt_preempt);
  assign pos_done    = position_done_in || (cur_cfg[`MPS_F_OVERLAP] && decel_phase_in);
  assign pos_continue = cur_cfg[`MPS_F_TYPE] == `MPS_TYPE_POS_AUTO || nxt_preempt || cur_cfg[`MPS_F_OVERLAP];

  // External path select has priority over the software trigger
  assign ext_idx  = path_select_strobe_in ? path_select_inputs_in : trig_idx_ff;
  assign ext_take = (path_select_strobe_in || trig_req_ff) && ext_idx != 6'h00 &&
                    (state_ff == MPS_IDLE || cfg_mem[ext_idx][`MPS_F_PREEMPT]);

  // On an internal call the previous move has ended at its target, so that target is the base
  always_comb
  begin
    base = 32'sh0000_0000;
    case (mps_tgt_mode_type'(cur_cfg[`MPS_F_MODE]))
      MPS_TGT_FIXED:   base = 32'sh0000_0000;
      MPS_TGT_PRESENT: base = internal_ff ? target_position_out : present_position_in;
      MPS_TGT_PREV:    base = target_position_out;
      MPS_TGT_LATCHED: base = latched_position_in;
      default:         base = 32'sh0000_0000;
    endcase
  end
  assign nxt_target = base + cur_data;

  assign spd_target = (cur_data > `MPS_SPEED_MAX) ? `MPS_SPEED_MAX :
                      (cur_data < `MPS_SPEED_MIN) ? `MPS_SPEED_MIN : cur_data;
  // Step per tick is the rated speed shortened by the time index; never zero
  assign ramp_step  = (`MPS_RATED_X10 >> cur_cfg[`MPS_F_ACC]) | 32'h0000_0001;
  assign ramp_load  = state_ff == MPS_LOAD && !ext_take && is_speed;

  mps_ramp u_ramp
  (
    .clock_in    (clock_in),
    .rstn_in     (rstn_in),
    .tick_in     (tick_ff),
    .load_in     (ramp_load),
    .target_in   (spd_target),
    .step_in     (ramp_step),
    .vel_out     (velocity_cmd_out),
    .reached_out (reached)
  );

  // Path state machine
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_ff    <= MPS_IDLE;
      path_ff     <= 6'h00;
      internal_ff <= 1'b0;
    end
    else if (ext_take)
    begin
      state_ff    <= MPS_LOAD;
      path_ff     <= ext_idx;
      internal_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        MPS_IDLE: state_ff <= MPS_IDLE;
        MPS_LOAD:
        begin
          if (skip)
          begin
            path_ff     <= nxt_idx;
            internal_ff <= 1'b1;
          end
          else if (is_speed || is_pos)
            state_ff <= MPS_RUN;
          else
            state_ff <= MPS_IDLE;
        end
        MPS_RUN:
        begin
          if (is_speed && reached)
            state_ff <= cur_cfg[`MPS_F_AUTO] ? MPS_WAIT : MPS_IDLE;
          else if (is_pos && pos_done)
            state_ff <= pos_continue ? MPS_WAIT : MPS_IDLE;
        end
        MPS_WAIT:
        begin
          if (dly_cnt_ff == 8'h00)
          begin
            state_ff    <= MPS_LOAD;
            path_ff     <= nxt_idx;
            internal_ff <= 1'b1;
          end
        end
        default: state_ff <= MPS_IDLE;
      endcase
    end
  end

  // Delay counter; a preempting load throws the pending delay away
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      dly_cnt_ff  <= 8'h00;
      counting_ff <= 1'b0;
    end
    else if (ext_take)
    begin
      dly_cnt_ff  <= 8'h00;
      counting_ff <= 1'b0;
    end
    else if (state_ff == MPS_LOAD && !skip)
    begin
      dly_cnt_ff  <= cur_dly;
      counting_ff <= from_start;
    end
    else
    begin
      if (state_ff == MPS_RUN && (is_speed ? reached : pos_done))
        counting_ff <= 1'b1;
      if ((counting_ff || state_ff == MPS_WAIT) && tick_ff && dly_cnt_ff != 8'h00)
        dly_cnt_ff <= dly_cnt_ff - 8'h01;
    end
  end

  // Motion command registers
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      move_start_out            <= 1'b0;
      target_position_out       <= 32'sh0000_0000;
      speed_mode_out            <= 1'b0;
      speed_unit_out            <= 1'b0;
      speedup_time_index_out    <= 4'h0;
      slowdown_time_index_out   <= 4'h0;
      target_velocity_index_out <= 4'h0;
    end
    else
    begin
      move_start_out <= 1'b0;
      if (state_ff == MPS_LOAD && !ext_take && !skip && (is_speed || is_pos))
      begin
        move_start_out            <= 1'b1;
        speed_mode_out            <= is_speed;
        speed_unit_out            <= cur_cfg[`MPS_F_UNIT];
        speedup_time_index_out    <= cur_cfg[`MPS_F_ACC];
        slowdown_time_index_out   <= cur_cfg[`MPS_F_DEC];
        target_velocity_index_out <= cur_cfg[`MPS_F_SPD];
        if (is_pos)
          target_position_out <= nxt_target;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      active_path_out <= 6'h00;
      busy_out        <= 1'b0;
    end
    else
    begin
      active_path_out <= path_ff;
      busy_out        <= state_ff != MPS_IDLE;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  sequence load_issue_s;
    state_ff == MPS_LOAD && !ext_take && !skip && (is_speed || is_pos);
  endsequence

  ext_preempt_a: assert property (ext_take |=> state_ff == MPS_LOAD && path_ff == $past(ext_idx)
    ##1 (move_start_out || state_ff != MPS_RUN)) else $error("preempting trigger not merged");
  skip_path_a: assert property (state_ff == MPS_LOAD && skip && !ext_take |=>
    state_ff == MPS_LOAD && path_ff == $past(nxt_idx) && !move_start_out) else $error("skip failed");
  speed_wait_a: assert property (state_ff == MPS_RUN && is_speed && !reached && !ext_take
    |=> state_ff != MPS_WAIT) else $error("delay before speed reached");
  single_stop_a: assert property (state_ff == MPS_RUN && is_pos && pos_done && !pos_continue
    && !ext_take |=> state_ff == MPS_IDLE) else $error("single path did not stop");
  auto_pos_a: assert property (state_ff == MPS_RUN && cur_cfg[`MPS_F_TYPE] == `MPS_TYPE_POS_AUTO
    && position_done_in && !ext_take |=> state_ff == MPS_WAIT) else $error("auto path did not advance");
  delay_end_a: assert property (state_ff == MPS_WAIT && dly_cnt_ff == 8'h00 && !ext_take
    |=> state_ff == MPS_LOAD && internal_ff) else $error("next path not called");
  fixed_target_a: assert property (load_issue_s and (is_pos && cur_cfg[`MPS_F_MODE] == 2'h0)
    |=> move_start_out && target_position_out == $past(cur_data)) else $error("fixed target wrong");
  speed_limit_a: assert property (velocity_cmd_out <= `MPS_SPEED_MAX
    && velocity_cmd_out >= `MPS_SPEED_MIN) else $error("speed command out of range");
  from_start_a: assert property (load_issue_s and from_start |=> counting_ff
    && dly_cnt_ff == $past(cur_dly)) else $error("delay not counted from start");

endmodule : mps_sequencer

// File: src/mps_defs.svh
// Constants for the motion path sequencer: offsets, field positions, reset values, timing
`ifndef MPS_DEFS_SVH
`define MPS_DEFS_SVH

`define MPS_CLK_PERIOD_NS   10
`define MPS_TICK_NS         1000000
`define MPS_MERGE_NS        1000000
`define MPS_TICK_CYC        (`MPS_TICK_NS / `MPS_CLK_PERIOD_NS)
`define MPS_MERGE_CYC       (`MPS_MERGE_NS / `MPS_CLK_PERIOD_NS)
`define MPS_DLY_STEP_MS     8'h0a

`define MPS_REG_TRIGGER     12'h004
`define MPS_REG_STATUS      12'h008
`define MPS_REG_LAST_TGT    12'h00c
`define MPS_PAGE_CFG        4'h1
`define MPS_PAGE_DATA       4'h2

`define MPS_PATH_COUNT      6'h3f
`define MPS_CFG_RESET       32'h0000_0000
`define MPS_DATA_RESET      32'h0000_0000

`define MPS_F_TYPE          3:0
`define MPS_F_PREEMPT       4
`define MPS_F_OVERLAP       5
`define MPS_F_AUTO          6
`define MPS_F_UNIT          7
`define MPS_F_MODE          9:8
`define MPS_F_ACC           13:10
`define MPS_F_DEC           17:14
`define MPS_F_SPD           21:18
`define MPS_F_DLY           25:22

`define MPS_TYPE_SPEED      4'h1
`define MPS_TYPE_POS_SINGLE 4'h2
`define MPS_TYPE_POS_AUTO   4'h3

`define MPS_SPEED_MAX       32'sh0000_ea60
`define MPS_SPEED_MIN       (-32'sh0000_ea60)
`define MPS_RATED_X10       32'h0000_7530

`endif

// File: src/mps_pkg.sv
// Types shared by the motion path sequencer modules
package mps_pkg;

  typedef enum logic [1:0]
  {
    MPS_IDLE = 2'h0,
    MPS_LOAD = 2'h1,
    MPS_RUN  = 2'h3,
    MPS_WAIT = 2'h2
  } mps_state_type;

  typedef enum logic [1:0]
  {
    MPS_TGT_FIXED   = 2'h0,
    MPS_TGT_PRESENT = 2'h1,
    MPS_TGT_PREV    = 2'h2,
    MPS_TGT_LATCHED = 2'h3
  } mps_tgt_mode_type;

endpackage : mps_pkg

// File: src/mps_ramp.sv
// Velocity ramp: steps the commanded speed toward a target once per millisecond tick
`timescale 1ns/1ps
module mps_ramp
  import mps_pkg::*;
(
  // Clock and reset
  input  wire logic               clock_in,
  input  wire logic               rstn_in,
  // Control
  input  wire logic               tick_in,
  input  wire logic               load_in,
  input  wire logic signed [31:0] target_in,
  input  wire logic        [31:0] step_in,
  // Result
  output logic signed      [31:0] vel_out,
  output logic                    reached_out
);

  logic signed [31:0] tgt_ff;
  logic signed [31:0] diff;

  assign diff = tgt_ff - vel_out;

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      tgt_ff <= 32'sh0000_0000;
    else if (load_in)
      tgt_ff <= target_in;
  end

  // Starts from whatever speed is present, not from zero
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      vel_out <= 32'sh0000_0000;
    else if (tick_in && !load_in)
    begin
      if (diff > $signed(step_in))
        vel_out <= vel_out + $signed(step_in);
      else if (diff < -$signed(step_in))
        vel_out <= vel_out - $signed(step_in);
      else
        vel_out <= tgt_ff;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      reached_out <= 1'b1;
    else if (load_in)
      reached_out <= 1'b0;
    else
      reached_out <= (vel_out == tgt_ff);
  end

endmodule : mps_ramp

// File: dv/mps_motor_model.sv
// Motor partner: answers positioning commands with feedback after a set travel time
`timescale 1ns/1ps
module mps_motor_model
(
  // Clock and reset
  input  wire logic               clock_in,
  input  wire logic               rstn_in,
  // Command side
  input  wire logic               move_start_in,
  input  wire logic               speed_mode_in,
  input  wire logic signed [31:0] target_in,
  input  wire logic        [15:0] travel_cyc_in,
  // Feedback
  output logic                    position_done_out,
  output logic                    decel_phase_out,
  output logic signed      [31:0] present_position_out,
  output logic signed      [31:0] latched_position_out
);
  logic        [15:0] count_ff;
  logic signed [31:0] goal_ff;
  logic               done_ff;

  // A new command hides the old done level at once, so the sequencer never takes it for the new move
  assign position_done_out = done_ff && !move_start_in;

  // Position creeps while moving so a stale value is never mistaken for the goal
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      count_ff             <= 16'h0000;
      goal_ff              <= 32'sh0000_0000;
      done_ff              <= 1'b0;
      decel_phase_out      <= 1'b0;
      present_position_out <= 32'sh0000_0000;
      latched_position_out <= 32'sh0000_1234;
    end
    else if (move_start_in)
    begin
      done_ff           <= 1'b0;
      decel_phase_out   <= 1'b0;
      goal_ff           <= target_in;
      count_ff          <= speed_mode_in ? 16'h0000 : travel_cyc_in;
    end
    else if (count_ff != 16'h0000)
    begin
      count_ff             <= count_ff - 16'h0001;
      present_position_out <= present_position_out + 32'sh0000_0001;
      decel_phase_out      <= (count_ff <= 16'h0004) && (count_ff != 16'h0001);
      if (count_ff == 16'h0001)
      begin
        done_ff              <= 1'b1;
        present_position_out <= goal_ff;
        latched_position_out <= goal_ff ^ 32'sh0000_0f0f;
      end
    end
  end
endmodule : mps_motor_model

// File: dv/tb_mps_sequencer.sv
// Self-checking testbench for the motion path sequencer
`timescale 1ns/1ps
`include "mps_defs.svh"
module tb_mps_sequencer;
  import mps_pkg::*;
  localparam int TCK = 10;
  logic clock_in = 1'b0, rstn_in = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, strobe = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0]  sel = 4'h0, msk;
  logic [31:0] wdat = 32'h0, rd_q, d, d1, pre;
  logic [5:0]  psel = 6'h00;
  logic [15:0] lat = 16'h0006;
  logic [31:0] wb_dat_out, vel, tgt;
  logic        wb_ack_out, move_start_out, speed_mode_out, speed_unit_out, busy_out, done, decel;
  logic [3:0]  acc_idx, dec_idx, vel_idx;
  logic [5:0]  active_path_out;
  logic signed [31:0] pres, latp;
  int err_count = 0, cmp_count = 0, seed = 53, c, i;

  always #5 clock_in = ~clock_in;

  mps_sequencer #(.TICK_CYCLES(TCK)) mps_sequencer_i (.clock_in(clock_in), .rstn_in(rstn_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .path_select_inputs_in(psel),
    .path_select_strobe_in(strobe), .position_done_in(done), .decel_phase_in(decel),
    .present_position_in(pres), .latched_position_in(latp), .move_start_out(move_start_out),
    .target_position_out(tgt), .velocity_cmd_out(vel), .speed_mode_out(speed_mode_out),
    .speed_unit_out(speed_unit_out), .speedup_time_index_out(acc_idx), .slowdown_time_index_out(dec_idx),
    .target_velocity_index_out(vel_idx), .active_path_out(active_path_out), .busy_out(busy_out));

  mps_motor_model mps_motor_model_i (.clock_in(clock_in), .rstn_in(rstn_in), .move_start_in(move_start_out),
    .speed_mode_in(speed_mode_out), .target_in(tgt), .travel_cyc_in(lat), .position_done_out(done),
    .decel_phase_out(decel), .present_position_out(pres), .latched_position_out(latp));

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic chk_span(input int got, input int lo, input int hi, input string what);
    cmp_count++;
    if (got < lo || got > hi)
    begin
      err_count++;
      $display("BAD %0t %s took %0d cycles", $time, what, got);
    end
  endtask : chk_span

  // Holds the request until ack is sampled at a rising edge
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] dv, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clock_in);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= dv; sel <= s;
    do begin @(posedge clock_in); n++; end while (wb_ack_out !== 1'b1 && n < 50);
    rd_q = wb_dat_out;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    chk_span(n, 1, 49, "bus answer");
  endtask : wb

  task automatic wait_move(input int bound);
    c = 0;
    do begin @(posedge clock_in); c++; end while (move_start_out !== 1'b1 && c < bound);
  endtask : wait_move

  task automatic wait_idle();
    int n;
    n = 0;
    do begin @(posedge clock_in); n++; end while (busy_out !== 1'b0 && n < 2000);
    chk_span(n, 1, 1999, "sequence end");
  endtask : wait_idle

  task automatic trig_hw(input logic [5:0] n);
    @(posedge clock_in);
    psel <= n; strobe <= 1'b1;
    @(posedge clock_in);
    strobe <= 1'b0;
  endtask : trig_hw

  function automatic logic [11:0] ad(input logic [3:0] page, input logic [5:0] n);
    ad = {page, n, 2'b00};
  endfunction : ad

  function automatic logic [31:0] cfg(input logic [3:0] ty, input logic pr, input logic ov, input logic au,
                                      input logic un, input logic [1:0] md, input logic [3:0] dl);
    cfg = 32'h0;
    cfg[`MPS_F_TYPE] = ty; cfg[`MPS_F_PREEMPT] = pr; cfg[`MPS_F_OVERLAP] = ov; cfg[`MPS_F_AUTO] = au;
    cfg[`MPS_F_UNIT] = un; cfg[`MPS_F_MODE] = md; cfg[`MPS_F_DLY] = dl;
  endfunction : cfg

  function automatic logic [31:0] calc_tgt(input logic [1:0] md, input logic [31:0] dv, input logic [31:0] p,
                                           input logic [31:0] pv, input logic [31:0] l);
    case (md)
      2'h0: calc_tgt = dv;
      2'h1: calc_tgt = p + dv;
      2'h2: calc_tgt = pv + dv;
      default: calc_tgt = l + dv;
    endcase
  endfunction : calc_tgt

  task automatic path(input logic [5:0] n, input logic [31:0] cf, input logic [31:0] dv);
    wb(1'b1, ad(`MPS_PAGE_CFG, n), cf, 4'hf);
    wb(1'b1, ad(`MPS_PAGE_DATA, n), dv, 4'hf);
  endtask : path

  initial
  begin
    #(200_000);
    err_count++;
    test_done();
  end

  initial
  begin
    repeat (16) @(posedge clock_in);
    rstn_in <= 1'b1;
    @(posedge clock_in);
    chk({busy_out, move_start_out, active_path_out}, 32'h0, "outputs after reset");
    wb(1'b0, ad(`MPS_PAGE_CFG, 6'h01), 32'h0, 4'hf);
    chk(rd_q, `MPS_CFG_RESET, "table reset");
    wb(1'b0, 12'h300, 32'h0, 4'hf);
    chk(rd_q, 32'h0, "unmapped read");
    // Byte lanes merge into the stored signed word
    for (i = 0; i < 4; i++)
    begin
      d = $random(seed);
      d1 = $random(seed);
      msk = 4'($random(seed));
      c = 1 + ($unsigned($random(seed)) % 63);
      wb(1'b1, ad(`MPS_PAGE_DATA, c[5:0]), d, 4'hf);
      wb(1'b1, ad(`MPS_PAGE_DATA, c[5:0]), d1, msk);
      for (int b = 0; b < 4; b++)
        if (msk[b])
          d[8*b +: 8] = d1[8*b +: 8];
      wb(1'b0, ad(`MPS_PAGE_DATA, c[5:0]), 32'h0, 4'hf);
      chk(rd_q, d, "data word");
    end
    // Every target mode, first four runs by pin trigger, last four by software trigger
    pre = 32'h0;
    for (i = 0; i < 8; i++)
    begin
      d = (i == 0) ? 32'h8000_0000 : $random(seed);
      path(6'h02, cfg(`MPS_TYPE_POS_SINGLE, 1'b0, 1'b0, 1'b0, 1'b0, i[1:0], 4'h0), d);
      d1 = calc_tgt(i[1:0], d, pres, pre, latp);
      if (i[2]) wb(1'b1, `MPS_REG_TRIGGER, 32'h2, 4'hf);
      else trig_hw(6'h02);
      wait_move(20);
      chk(tgt, d1, "target by mode");
      chk({speed_mode_out, active_path_out}, 32'h2, "single path issued");
      pre = d1;
      wait_idle();
      wait_move(30);
      chk(c, 30, "stays stopped");
    end
    // Auto positioning with a 10 tick delay, then a single path
    path(6'h05, cfg(`MPS_TYPE_POS_AUTO, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 4'h1), 32'h0000_0100);
    path(6'h06, cfg(`MPS_TYPE_POS_SINGLE, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 4'h0), 32'hffff_ff00);
    trig_hw(6'h05);
    wait_move(20);
    wait_move(2000);
    // Delays count whole ticks, so the first tick may fall early
    chk_span(c, 6 + 9 * TCK, 30 + 10 * TCK, "advance after delay");
    chk(active_path_out, 32'h06, "next path");
    chk(tgt, 32'hffff_ff00, "next target");
    wait_idle();
    // Speed path clamped to 60000, two ticks of ramp, then a timed hand-off
    path(6'h0a, cfg(`MPS_TYPE_SPEED, 1'b0, 1'b0, 1'b1, 1'b1, 2'h0, 4'h1), 32'd70000);
    path(6'h0b, cfg(`MPS_TYPE_POS_SINGLE, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 4'h0), 32'h0000_0777);
    trig_hw(6'h0a);
    wait_move(20);
    chk({speed_mode_out, speed_unit_out}, 32'h3, "speed command");
    wait_move(2000);
    chk(vel, `MPS_SPEED_MAX, "speed clamp");
    chk_span(c, 1 + 11 * TCK, 40 + 12 * TCK, "ramp then delay");
    chk({speed_mode_out, active_path_out}, 32'h0b, "position after speed");
    wait_idle();
    // Overlap hands off during deceleration; overlapped path has zero delay
    lat <= 16'd40;
    path(6'h28, cfg(`MPS_TYPE_POS_SINGLE, 1'b0, 1'b1, 1'b0, 1'b0, 2'h0, 4'h0), 32'h0000_4000);
    path(6'h29, cfg(`MPS_TYPE_POS_SINGLE, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 4'h0), 32'h0000_5000);
    trig_hw(6'h28);
    wait_move(20);
    wait_move(200);
    chk_span(c, 30, 41, "overlap start");
    chk(active_path_out, 32'h29, "overlap path");
    wait_idle();
    // Zero-delay path skipped for its preempting neighbour; then external preempt versus a plain trigger
    lat <= 16'd400;
    path(6'h14, cfg(`MPS_TYPE_POS_SINGLE, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 4'h0), 32'h0001_0000);
    path(6'h15, cfg(`MPS_TYPE_POS_SINGLE, 1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 4'h0), 32'h0002_0000);
    path(6'h16, cfg(`MPS_TYPE_POS_SINGLE, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 4'h0), 32'h0003_0000);
    path(6'h18, cfg(`MPS_TYPE_POS_SINGLE, 1'b1, 1'b0, 1'b0, 1'b0, 2'h0, 4'h0), 32'h0004_0000);
    trig_hw(6'h14);
    wait_move(20);
    chk(active_path_out, 32'h15, "skip to preempting path");
    trig_hw(6'h16);
    wait_move(20);
    chk(c, 20, "plain trigger dropped");
    trig_hw(6'h18);
    wait_move(5);
    chk_span(c, 1, 4, "preempt merge");
    chk(active_path_out, 32'h18, "preempting path");
    chk(tgt, 32'h0004_0000, "preempting target");
    wait_idle();
    test_done();
  end
endmodule : tb_mps_sequencer
